// [verification/enc_out_assertions.sv]
// Purpose: Port checks for the encoder emulation block
// Assumes: One clock, active-low asynchronous reset
// Notes: Bound to every enc_out_emulator instance
`timescale 1ns/1ps
module enc_out_assertions (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	// Bus handshakes
	input wire logic S_AXI_AWVALID_I,
	input wire logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input wire logic S_AXI_WREADY_O,
	input wire logic [1:0] S_AXI_BRESP_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_ARVALID_I,
	input wire logic S_AXI_ARREADY_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// Encoder outputs and alarm
	input wire enc_out_pkg::quad_t ENC_O,
	input wire enc_out_pkg::quad_t ENC_N_O,
	input wire logic ENCODER_OUTPUT_ALARM_O,
	input wire logic [7:0] ALARM_SUBCODE_O
);
	import enc_out_pkg::*;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!NRST_I);
	////////////////////////////////////////////////////////////////////////////////
	// Handshake steps
	sequence wr_taken;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence rd_taken;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	// Output lines and alarm
	AST_COMPLEMENT: assert property (ENC_N_O == ~ENC_O)
		else $error("complement output differs");
	AST_SUBCODE: assert property (ALARM_SUBCODE_O == (ENCODER_OUTPUT_ALARM_O ? 8'h01 : 8'h00))
		else $error("alarm subcode wrong");
	AST_ALARM_STICKY: assert property (ENCODER_OUTPUT_ALARM_O |=> ENCODER_OUTPUT_ALARM_O)
		else $error("alarm dropped without reset");
	// Register bus
	AST_B_ANSWER: assert property (wr_taken |-> ##[1:3] S_AXI_BVALID_O)
		else $error("write response missing");
	AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response not held");
	AST_B_DROP: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
		else $error("write response repeated");
	AST_B_REFUSE: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write taken during response");
	AST_R_ANSWER: assert property (rd_taken |=> S_AXI_RVALID_O)
		else $error("read data late");
	AST_R_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data not held");
	AST_R_REFUSE: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
		else $error("read taken during response");
endmodule

bind enc_out_emulator enc_out_assertions i_chk (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I),
	.S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
	.S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
	.S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
	.ENC_O(ENC_O), .ENC_N_O(ENC_N_O), .ENCODER_OUTPUT_ALARM_O(ENCODER_OUTPUT_ALARM_O),
	.ALARM_SUBCODE_O(ALARM_SUBCODE_O));

// [verification/quad_counter_model.sv]
// Purpose: Counter input of the receiving equipment
// Assumes: Quadrature lines sampled on the system clock
// Notes: Counts up for one phase order and down for the other
`timescale 1ns/1ps
module quad_counter_model (
	// Clock and clear
	input wire logic clk_i,
	input wire logic clr_i,
	// Encoder lines
	input wire enc_out_pkg::quad_t quad_i,
	// Totals
	output int count_o,
	output int zeros_o,
	output int zero_at_o,
	output int skips_o
);
	import enc_out_pkg::*;
	logic [1:0] prev = 2'h0;
	logic prev_z = 1'h0;
	logic [1:0] d;
	// Gray step index of the A/B pair
	function automatic logic [1:0] phase(input logic a, input logic b);
		return {b, a ^ b};
	endfunction
	// Decode steps, skipped steps and zero pulses
	always @(posedge clk_i) begin
		d = phase(quad_i.a, quad_i.b) - phase(prev[1], prev[0]);
		if (clr_i) begin
			count_o <= 0;
			zeros_o <= 0;
			skips_o <= 0;
		end else begin
			if (d == 2'h1) count_o <= count_o + 1;
			if (d == 2'h3) count_o <= count_o - 1;
			if (d == 2'h2) skips_o <= skips_o + 1;
			if (quad_i.z && !prev_z) begin
				zeros_o <= zeros_o + 1;
				zero_at_o <= count_o;
			end
		end
		prev <= {quad_i.a, quad_i.b};
		prev_z <= quad_i.z;
	end
endmodule

// [verification/test_enc_out_emulator.sv]
// Purpose: Self-checking bench for the encoder emulation block
// Assumes: 50 MHz clock, counter model on the encoder lines
// Notes: Phase sign is taken from the first synthesized turn
`timescale 1ns/1ps
module test_enc_out_emulator;
	import enc_out_pkg::*;
	typedef struct {int src; int ppr; int inv; int rev; int sh; int exp;} row_t;
	logic clk = 1'h0, nrst = 1'h0, clr = 1'h1, marker = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, subcode;
	logic [31:0] wdata = 32'h0, pos = 32'h80400000, rdata, rdv;
	logic [15:0] speed = 16'h03E8;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, alarm;
	quad_t s1 = 3'h4, s2 = 3'h2, fin = 3'h1, enc, enc_n;
	int count, zeros, zero_at, skips, sg, z0, failures = 0, total_checks = 0;
	row_t rows[11] = '{'{1, 5, 0, 0, 0, 4}, '{2, 5, 0, 0, 0, 2}, '{3, 5, 0, 0, 0, 1},
		'{0, 1, 0, 0, 0, 256}, '{0, 2, 0, 0, 0, 512}, '{0, 1, 1, 0, 0, -256}, '{0, 1, 0, 1, 0, -256},
		'{0, 1, 0, 0, 1, 256}, '{0, 1, 0, 0, 2, 256}, '{0, 1, 0, 0, 3, 256}, '{0, 0, 0, 0, 0, 0}};
	////////////////////////////////////////////////////////////////////////////////
	// Device and far-side counter
	enc_out_emulator i_dut (.SYS_CLK_I(clk), .NRST_I(nrst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .MOTOR_POSITION_I(pos),
		.SENSOR_TWO_POSITION_I(32'h0), .SPEED_REF_STEP_I(32'h0), .MAX_SPEED_RPM_I(speed), .SENSOR_ONE_I(s1),
		.SENSOR_TWO_I(s2), .FREQ_IN_I(fin), .ZERO_MARKER_I(marker), .ENC_O(enc), .ENC_N_O(enc_n),
		.ENCODER_OUTPUT_ALARM_O(alarm), .ALARM_SUBCODE_O(subcode));
	quad_counter_model i_far (.clk_i(clk), .clr_i(clr), .quad_i(enc), .count_o(count), .zeros_o(zeros),
		.zero_at_o(zero_at), .skips_o(skips));
	// Clock
	initial begin
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Report and checks
	task automatic end_sim();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] cfgw(input int src, input int ppr, input int inv, input int sh, input int pl);
		return (32'(pl) << POLE_LSB) | (32'(src) << SOURCE_LSB) | (32'(ppr) << PPR_LSB) | (32'(inv) << INVERT_BIT)
			| 32'(sh);
	endfunction
	// Bus cycles, handshakes sampled mid-cycle and acted on at the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw_ok, w_ok, b_ok;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bvalid;
			@(posedge clk);
			if (aw_ok) awvalid <= 1'h0;
			if (w_ok) wvalid <= 1'h0;
			if (b_ok) break;
		end
		bready <= 1'h0;
		if (n == 50) begin
			failures++;
			end_sim();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		logic ar_ok, r_ok;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ar_ok = arvalid && arready;
			r_ok = rvalid;
			rdv = rdata;
			resp = rresp;
			@(posedge clk);
			if (ar_ok) arvalid <= 1'h0;
			if (r_ok) break;
		end
		rready <= 1'h0;
		if (n == 50) begin
			failures++;
			end_sim();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'h1;
		for (int i = 0; i < 11; i++) begin
			wr(CFG_OFFSET, cfgw(rows[i].src, rows[i].ppr, rows[i].inv, rows[i].sh, 2));
			if (rows[i].src != 0) begin
				repeat (4) @(posedge clk);
				chk(enc, rows[i].exp);
				chk(enc ^ enc_n, 32'h7);
			end else begin
				repeat (300) @(posedge clk);
				clr <= 1'h1;
				@(posedge clk);
				clr <= 1'h0;
				repeat (4096) @(posedge clk) pos <= rows[i].rev ? pos - 32'h00100000 : pos + 32'h00100000;
				repeat (300) @(posedge clk);
				if (i == 3) begin
					sg = count > 0 ? 1 : -1;
					z0 = zero_at;
				end
				chk(count, sg * rows[i].exp);
				chk(skips, 0);
				if (rows[i].ppr != 0) chk(zeros, 1);
				if (rows[i].sh != 0) chk(((zero_at - z0) * sg) & 255, 64 * rows[i].sh);
				chk(alarm, 0);
			end
		end
		// Zero pulse taken from the real marker
		wr(CFG_OFFSET, cfgw(4, 1, 0, 0, 2));
		marker <= 1'h1;
		repeat (4) @(posedge clk);
		chk(enc.z, 1);
		marker <= 1'h0;
		repeat (4) @(posedge clk);
		chk(enc.z, 0);
		// Pass-through refused for a resolver
		wr(CFG_OFFSET, cfgw(1, 5, 0, 0, 2) | 32'h03000000);
		repeat (4) @(posedge clk);
		chk(enc, 0);
		// Overspeed boundary, then pole pairs scale the speed
		speed <= 16'h00E6;
		wr(CFG_OFFSET, cfgw(0, 12, 0, 0, 2));
		repeat (10) @(posedge clk);
		chk(alarm, 0);
		speed <= 16'h0074;
		wr(CFG_OFFSET, cfgw(0, 12, 0, 0, 4));
		repeat (10) @(posedge clk);
		chk(alarm, 1);
		chk(subcode, 1);
		// Second reset clears the alarm and the settings
		nrst <= 1'h0;
		repeat (3) @(posedge clk);
		chk(alarm, 0);
		chk(enc_n, 32'h7);
		nrst <= 1'h1;
		rd(CFG_OFFSET);
		chk(rdv, cfgw(0, 5, 0, 0, 2));
		rd(GAIN_OFFSET);
		chk(rdv, 32'h00007FFF);
		rd(8'h20);
		chk(resp, 32'h2);
		chk(rdv, 32'h0);
		end_sim();
	end
endmodule

// [verilog/enc_out_emulator.sv]
// Purpose: Encoder emulation output with source selection and overspeed alarm
// Assumes: Sensor and frequency inputs are synchronous squared levels
// Notes: Configuration reached over AXI4-Lite
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Functional notes
// - Source 0 synthesizes from motor sensor position
// - Source 1 passes sensor one squares through
// - Source 1 only for encoder and sin/cos sensors
// - Source 2 sensor two, 3 frequency input
// - Source 4 synthesized A/B, real marker zero
// - Source 5 synthesizes from sensor two
// - Code 0 none, 1..12 is 64..131072
// - Resolution code resets to 5
// - Count scales with sensor pole pairs
// - Too high resolution raises alarm subcode 1
// - Channel frequency held at 500 kHz
// - Resolver pass-through resolution falls with speed; here source 1 drives zero outputs for a resolver
// - Mode 0 absolute with managed zero
// - Mode 1 incremental tracking
// - Mode 2 follows speed reference
// - Mode honoured only for marker sensors
// - One zero pulse per revolution
// - Zero shift steps of 90 degrees
// - B invert bit, reset 0
// - Phase relation follows direction and invert
// - Tracking loop with gain scale, 100 %
module enc_out_emulator (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	// AXI4-Lite write address and data
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// AXI4-Lite read
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// Position sources
	input wire logic [31:0] MOTOR_POSITION_I,
	input wire logic [31:0] SENSOR_TWO_POSITION_I,
	input wire logic [31:0] SPEED_REF_STEP_I,
	input wire logic [15:0] MAX_SPEED_RPM_I,
	// Squared pass-through signals
	input wire enc_out_pkg::quad_t SENSOR_ONE_I,
	input wire enc_out_pkg::quad_t SENSOR_TWO_I,
	input wire enc_out_pkg::quad_t FREQ_IN_I,
	input wire logic ZERO_MARKER_I,
	// Encoder outputs, true and complement
	output enc_out_pkg::quad_t ENC_O,
	output enc_out_pkg::quad_t ENC_N_O,
	// Alarm
	output logic ENCODER_OUTPUT_ALARM_O,
	output logic [7:0] ALARM_SUBCODE_O
);
	import enc_out_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Configuration state
	enc_cfg_t cfg;
	logic [15:0] loop_gain_scale;
	logic [15:0] speed_limit_scale;
	logic alarm;
	logic [31:0] reference_position;

	////////////////////////////////////////////////////////////////////////
	// Bus write channel: address and data taken in either order
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic bvalid;
	logic write_fire;
	logic [31:0] wmask;

	assign S_AXI_AWREADY_O = !aw_held && !bvalid;
	assign S_AXI_WREADY_O = !w_held && !bvalid;
	assign write_fire = aw_held && w_held && !bvalid;
	assign S_AXI_BVALID_O = bvalid;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[gi * 8 +: 8] = {8{w_strb[gi]}};
		end
	endgenerate

	logic addr_cfg;
	logic addr_gain;
	logic addr_limit;
	logic write_known;
	logic [31:0] cfg_word;
	logic [31:0] next_cfg_word;
	logic [3:0] req_ppr;
	logic [3:0] next_ppr;

	assign addr_cfg = aw_addr == CFG_OFFSET;
	assign addr_gain = aw_addr == GAIN_OFFSET;
	assign addr_limit = aw_addr == SPEED_LIMIT_OFFSET;
	assign write_known = addr_cfg || addr_gain || addr_limit;
	assign cfg_word = {5'h00, cfg.sensor_kind, cfg.sensor_pole_count, 2'h0, cfg.synthesis_mode, 1'b0,
		cfg.output_source_select, cfg.ppr_code, 1'b0, cfg.b_channel_invert, cfg.zero_pulse_shift};
	assign next_cfg_word = (cfg_word & ~wmask) | (w_data & wmask);
	assign req_ppr = next_cfg_word[PPR_LSB +: 4];
	// Codes above 12 are clamped to the top code
	assign next_ppr = (req_ppr > PPR_CODE_MAX) ? PPR_CODE_MAX : req_ppr;

	// Write handshake and register update
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			S_AXI_BRESP_O <= RESP_OKAY;
			cfg.zero_pulse_shift <= SHIFT_RESET;
			cfg.b_channel_invert <= INVERT_RESET;
			cfg.ppr_code <= PPR_RESET;
			cfg.output_source_select <= SOURCE_RESET;
			cfg.synthesis_mode <= MODE_RESET;
			cfg.sensor_pole_count <= POLE_RESET;
			cfg.sensor_kind <= SENSOR_RESET;
			loop_gain_scale <= GAIN_RESET;
			speed_limit_scale <= SPEED_LIMIT_RESET;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA_I;
				w_strb <= S_AXI_WSTRB_I;
			end
			if (write_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				S_AXI_BRESP_O <= write_known ? RESP_OKAY : RESP_SLVERR;
				if (addr_cfg) begin
					cfg.zero_pulse_shift <= next_cfg_word[SHIFT_LSB +: 2];
					cfg.b_channel_invert <= next_cfg_word[INVERT_BIT];
					cfg.ppr_code <= next_ppr;
					cfg.output_source_select <= (next_cfg_word[SOURCE_LSB +: 3] > SRC_SYNTH_SENSOR_TWO) ?
						cfg.output_source_select : next_cfg_word[SOURCE_LSB +: 3];
					cfg.synthesis_mode <= (next_cfg_word[MODE_LSB +: 2] > MODE_REFERENCE) ?
						cfg.synthesis_mode : next_cfg_word[MODE_LSB +: 2];
					cfg.sensor_pole_count <= next_cfg_word[POLE_LSB +: 8];
					cfg.sensor_kind <= next_cfg_word[SENSOR_LSB +: 3];
				end
				if (addr_gain) begin
					// Gain above full scale is clamped to 100 %
					loop_gain_scale <= (next_cfg_word[15:0] & 16'h0000) |
						(((w_data[15:0] & wmask[15:0]) > 16'h7FFF) ? 16'h7FFF : (w_data[15:0] & wmask[15:0]));
				end
				if (addr_limit) begin
					speed_limit_scale <= (speed_limit_scale & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
				end
			end else if (bvalid && S_AXI_BREADY_I) begin
				bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus read channel: one cycle to data
	logic [31:0] read_word;
	logic [31:0] tracked_position;
	logic read_known;
	logic [31:0] status_word;

	assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
	assign status_word = {21'h000000, ENC_O.z, ENC_O.b, ENC_O.a, ALARM_SUBCODE_O};
	assign read_known = (S_AXI_ARADDR_I == CFG_OFFSET) || (S_AXI_ARADDR_I == GAIN_OFFSET) ||
		(S_AXI_ARADDR_I == SPEED_LIMIT_OFFSET) || (S_AXI_ARADDR_I == STATUS_OFFSET) ||
		(S_AXI_ARADDR_I == POSITION_OFFSET);
	assign read_word = (S_AXI_ARADDR_I == CFG_OFFSET) ? cfg_word :
		(S_AXI_ARADDR_I == GAIN_OFFSET) ? {16'h0000, loop_gain_scale} :
		(S_AXI_ARADDR_I == SPEED_LIMIT_OFFSET) ? {16'h0000, speed_limit_scale} :
		(S_AXI_ARADDR_I == STATUS_OFFSET) ? status_word :
		(S_AXI_ARADDR_I == POSITION_OFFSET) ? tracked_position : 32'h00000000;

	// Read data register
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h00000000;
			S_AXI_RRESP_O <= RESP_OKAY;
		end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O <= read_word;
			S_AXI_RRESP_O <= read_known ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
			S_AXI_RVALID_O <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source and mode decode
	logic marker_sensor;
	logic passthrough_ok;
	logic [1:0] eff_mode;
	logic synth_source;
	logic [31:0] sensor_position;
	logic [31:0] shifted_position;
	logic [31:0] loop_target;

	assign marker_sensor = (cfg.sensor_kind == SENSOR_ENCODER) || (cfg.sensor_kind == SENSOR_ENCODER_HALL) ||
		(cfg.sensor_kind == SENSOR_SINCOS);
	assign passthrough_ok = (cfg.sensor_kind == SENSOR_ENCODER) || (cfg.sensor_kind == SENSOR_SINCOS);
	assign eff_mode = marker_sensor ? cfg.synthesis_mode : MODE_ABSOLUTE;
	assign synth_source = (cfg.output_source_select == SRC_SYNTH_MOTOR) ||
		(cfg.output_source_select == SRC_SYNTH_MARKER) || (cfg.output_source_select == SRC_SYNTH_SENSOR_TWO);
	assign sensor_position = (cfg.output_source_select == SRC_SYNTH_SENSOR_TWO) ?
		SENSOR_TWO_POSITION_I : MOTOR_POSITION_I;
	// Quarter-turn steps of electrical shift applied to the sensor zero
	assign shifted_position = sensor_position - (QUARTER_TURN * 32'(cfg.zero_pulse_shift));
	assign loop_target = (eff_mode == MODE_REFERENCE) ? reference_position : shifted_position;

	// Speed-reference position integrator for reference mode
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			reference_position <= 32'h00000000;
		end else begin
			reference_position <= reference_position + SPEED_REF_STEP_I;
		end
	end

	tracking_loop u_loop (
		.clk_i(SYS_CLK_I),
		.nrst_i(NRST_I),
		.target_i(loop_target),
		.gain_i(loop_gain_scale),
		.position_o(tracked_position)
	);

	////////////////////////////////////////////////////////////////////////
	// Resolution: pulses per electrical turn = 32 << code, four edges each
	logic [4:0] edge_shift;
	logic ppr_enable;
	enc_out_pkg::quad_t synth_quad;

	assign ppr_enable = cfg.ppr_code != 4'h0;
	// Electrical position already carries the pole pairs, so pulses scale with them
	assign edge_shift = 5'(6'd32 - 6'(PPR_BASE_SHIFT) - 6'(cfg.ppr_code) - 6'd2);

	quad_encoder u_quad (
		.clk_i(SYS_CLK_I),
		.nrst_i(NRST_I),
		.position_i(tracked_position),
		.edge_shift_i(edge_shift),
		.enable_i(ppr_enable),
		.quad_o(synth_quad)
	);

	////////////////////////////////////////////////////////////////////////
	// Overspeed: max rpm times pole pairs against the code's limit
	logic [23:0] speed_pairs;
	logic [31:0] ppr_limit;
	logic overspeed;
	logic resolver_overspeed;

	assign speed_pairs = 24'(MAX_SPEED_RPM_I) * 24'(cfg.sensor_pole_count >> 1);
	// Limit halves per code above 1024; 1024 allows 29440, codes up to 512 allow 32767
	assign ppr_limit = (cfg.ppr_code > BASE_SPEED_CODE) ?
		(32'(BASE_SPEED_RPM) >> (cfg.ppr_code - BASE_SPEED_CODE)) :
		(cfg.ppr_code == BASE_SPEED_CODE) ? 32'(BASE_SPEED_RPM) : 32'(TOP_SPEED_RPM);
	assign overspeed = synth_source && ppr_enable && (32'(speed_pairs) > ppr_limit);
	// Resolver pass-through: allowed speed set by the external converter scale
	assign resolver_overspeed = (cfg.output_source_select == SRC_SENSOR_ONE) &&
		(cfg.sensor_kind == SENSOR_RESOLVER) && (speed_pairs > 24'(speed_limit_scale));

	// Alarm latch, cleared only by reset
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			alarm <= 1'b0;
		end else if (overspeed || resolver_overspeed) begin
			alarm <= 1'b1;
		end
	end
	assign ENCODER_OUTPUT_ALARM_O = alarm;
	assign ALARM_SUBCODE_O = alarm ? ALARM_SUBCODE_PPR : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Output selection, B inversion and complements
	enc_out_pkg::quad_t next_enc;
	enc_out_pkg::quad_t chosen;

	always_comb begin
		case (cfg.output_source_select)
			SRC_SYNTH_MOTOR: chosen = synth_quad;
			SRC_SENSOR_ONE: chosen = passthrough_ok ? SENSOR_ONE_I : '0;
			SRC_SENSOR_TWO: chosen = SENSOR_TWO_I;
			SRC_FREQ_IN: chosen = FREQ_IN_I;
			SRC_SYNTH_MARKER: chosen = '{a: synth_quad.a, b: synth_quad.b, z: ZERO_MARKER_I};
			SRC_SYNTH_SENSOR_TWO: chosen = synth_quad;
			default: chosen = '0;
		endcase
	end
	assign next_enc.a = chosen.a;
	assign next_enc.b = chosen.b ^ cfg.b_channel_invert;
	assign next_enc.z = chosen.z;

	// Output registers with complementary lines
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ENC_O <= '0;
			ENC_N_O <= '1;
		end else begin
			ENC_O <= next_enc;
			ENC_N_O <= ~next_enc;
		end
	end
endmodule

// [verilog/enc_out_pkg.sv]
// Purpose: Shared constants and types for the encoder emulation output block
// Assumes: 50 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: Positions are 32-bit words of a full electrical turn (2^32 = 360 deg)
package enc_out_pkg;
	// Register byte offsets
	localparam logic [7:0] CFG_OFFSET = 8'h00;
	localparam logic [7:0] GAIN_OFFSET = 8'h04;
	localparam logic [7:0] SPEED_LIMIT_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0C;
	localparam logic [7:0] POSITION_OFFSET = 8'h10;
	// Configuration field positions
	localparam int SHIFT_LSB = 0;
	localparam int INVERT_BIT = 2;
	localparam int PPR_LSB = 4;
	localparam int SOURCE_LSB = 8;
	localparam int MODE_LSB = 12;
	localparam int POLE_LSB = 16;
	localparam int SENSOR_LSB = 24;
	// Reset values
	localparam logic [1:0] SHIFT_RESET = 2'h0;
	localparam logic INVERT_RESET = 1'b0;
	localparam logic [3:0] PPR_RESET = 4'h5;
	localparam logic [2:0] SOURCE_RESET = 3'h0;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [7:0] POLE_RESET = 8'h02;
	localparam logic [2:0] SENSOR_RESET = 3'h0;
	localparam logic [15:0] GAIN_RESET = 16'h7FFF;
	localparam logic [15:0] SPEED_LIMIT_RESET = 16'h0BB8;
	// Output source codes
	localparam logic [2:0] SRC_SYNTH_MOTOR = 3'h0;
	localparam logic [2:0] SRC_SENSOR_ONE = 3'h1;
	localparam logic [2:0] SRC_SENSOR_TWO = 3'h2;
	localparam logic [2:0] SRC_FREQ_IN = 3'h3;
	localparam logic [2:0] SRC_SYNTH_MARKER = 3'h4;
	localparam logic [2:0] SRC_SYNTH_SENSOR_TWO = 3'h5;
	// Synthesis modes
	localparam logic [1:0] MODE_ABSOLUTE = 2'h0;
	localparam logic [1:0] MODE_INCREMENTAL = 2'h1;
	localparam logic [1:0] MODE_REFERENCE = 2'h2;
	// Sensor kinds
	localparam logic [2:0] SENSOR_ENCODER = 3'h0;
	localparam logic [2:0] SENSOR_ENCODER_HALL = 3'h1;
	localparam logic [2:0] SENSOR_SINCOS = 3'h2;
	localparam logic [2:0] SENSOR_RESOLVER = 3'h3;
	localparam logic [2:0] SENSOR_SERIAL = 3'h4;
	// Resolution limits
	localparam logic [3:0] PPR_CODE_MAX = 4'hC;
	localparam logic [3:0] PPR_BASE_SHIFT = 4'h5;
	localparam int BASE_SPEED_RPM = 29440;
	localparam int TOP_SPEED_RPM = 32767;
	localparam logic [3:0] BASE_SPEED_CODE = 4'h5;
	localparam int MAX_CHANNEL_KHZ = 500;
	localparam logic [7:0] ALARM_SUBCODE_PPR = 8'h01;
	// Tracking loop: gain 32767 is 100 %
	localparam int GAIN_FULL_SCALE = 32767;
	localparam int LOOP_SHIFT = 15;
	localparam logic [31:0] QUARTER_TURN = 32'h40000000;
	// Output bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic a;
		logic b;
		logic z;
	} quad_t;

	typedef struct packed {
		logic [2:0] sensor_kind;
		logic [7:0] sensor_pole_count;
		logic [1:0] synthesis_mode;
		logic [2:0] output_source_select;
		logic [3:0] ppr_code;
		logic b_channel_invert;
		logic [1:0] zero_pulse_shift;
	} enc_cfg_t;
endpackage

// [verilog/quad_encoder.sv]
// Purpose: Turns a tracked position into A/B quadrature and zero pulse
// Assumes: Position is electrical, resolution given as a power of two
// Notes: Only one of A or B changes per quadrature step
`timescale 1ns/1ps
module quad_encoder (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Position and resolution
	input wire logic [31:0] position_i,
	input wire logic [4:0] edge_shift_i,
	input wire logic enable_i,
	// Quadrature out
	output enc_out_pkg::quad_t quad_o
);
	import enc_out_pkg::*;

	logic [31:0] scaled;
	logic [1:0] phase;
	logic [31:0] last_top;
	logic wrap;
	enc_out_pkg::quad_t next_quad;

	////////////////////////////////////////////////////////////////////////
	// Quadrature phase from the two bits below the edge count
	assign scaled = position_i >> edge_shift_i;
	assign phase = scaled[1:0];
	assign wrap = (position_i[31:30] == 2'h0) && (last_top[31:30] == 2'h3) ||
		(position_i[31:30] == 2'h3) && (last_top[31:30] == 2'h0);
	assign next_quad.a = enable_i & phase[1];
	assign next_quad.b = enable_i & (phase[1] ^ phase[0]);
	assign next_quad.z = enable_i & wrap;

	// Registered outputs
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			quad_o <= '0;
			last_top <= 32'h00000000;
		end else begin
			quad_o <= next_quad;
			last_top <= position_i;
		end
	end
endmodule

// [verilog/tracking_loop.sv]
// Purpose: First-order tracking loop that follows a position word
// Assumes: Target position wraps at 2^32 per electrical turn
// Notes: Step size is error times scaled gain, which gives the small jitter
`timescale 1ns/1ps
module tracking_loop (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Target and gain
	input wire logic [31:0] target_i,
	input wire logic [15:0] gain_i,
	// Tracked position
	output logic [31:0] position_o
);
	import enc_out_pkg::*;

	logic [31:0] position;
	logic [31:0] error;
	logic [47:0] product;
	logic [31:0] step;
	logic [31:0] next_position;

	////////////////////////////////////////////////////////////////////////
	// Error scaled by gain; full gain closes half the error every cycle
	assign error = target_i - position;
	assign product = 48'($signed(error)) * 48'(gain_i);
	assign step = product[47:16];
	assign next_position = position + step;
	assign position_o = position;

	// Loop integrator
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			position <= 32'h00000000;
		end else begin
			position <= next_position;
		end
	end
endmodule
